// ==== ccs_pkg.sv ====
// Constants, state codes and carrier types for the camera control slave
package ccs_pkg;

  // Register addresses (16-bit sub-address space)
  localparam logic [15:0] ADDR_SOFT_RESET = 16'h0040;
  localparam logic [15:0] ADDR_LOCK_CLR = 16'h5013;
  localparam logic [15:0] ADDR_ACQ_CNT = 16'h5015;
  localparam logic [15:0] ADDR_LOSS_CNT = 16'h5016;
  localparam logic [15:0] ADDR_LOCK_STATE = 16'h50DC;

  // Generic configuration bank page (high address byte)
  localparam logic [7:0] BANK_PAGE = 8'h40;
  localparam int BANK_DEPTH = 256;

  // Field positions
  localparam int LOCK_BIT = 0;
  localparam int MISSING_BIT = 1;
  localparam int CLR_BIT = 0;
  localparam int SOFT_BIT = 0;
  localparam int RW_BIT = 0;

  // Slave addressing
  localparam logic [4:0] LOCAL_PREFIX = 5'h15;
  localparam logic [7:0] GLOBAL_WR_BYTE = 8'hA2;

  // Byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] FIRST_BIT_SENT = 4'h1;
  localparam logic [1:0] PHASE_ADDR_HI = 2'h0;
  localparam logic [1:0] PHASE_ADDR_LO = 2'h1;
  localparam logic [1:0] PHASE_DATA = 2'h2;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [15:0] ADDR_STEP = 16'h0001;

  // Sampled pins, one packed carrier
  typedef struct packed {
    logic scl;
    logic sda;
    logic sel_hi;
    logic sel_lo;
    logic lock;
    logic missing;
  } ccs_pins_t;

  // Idle bus lines high, everything else low
  localparam ccs_pins_t PINS_IDLE = 6'h30;

  // Bus engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK = 6'h04,
    ST_RX = 6'h08,
    ST_TX = 6'h10,
    ST_MACK = 6'h20
  } ccs_state_t;

  // Register write request, registered between engine and register file
  typedef struct packed {
    logic stb;
    logic [15:0] addr;
    logic [7:0] data;
  } ccs_wreq_t;

endpackage

// ==== ccs_cci_slave.sv ====
// Two-wire camera control slave with register bank and PLL lock tracking
`timescale 1ns/10ps

// Behaviour
// - Works at 100 and 400 kbit/s
// - Two address bytes, high first, each acked
// - Registers 8-bit; undefined bits ignore, read zero
// - Burst advances address after each acked byte
// - Bit after address: 0 write, 1 read
// - Read: write address, repeated start, read, NACK
// - Slave acks address bytes; high means NACK
// - After read byte, release, continue only on ACK
// - Local address 10101 plus two select pins
// - Global address 10100010 write only
// - Start/stop are SDA edges while SCL high
// - Status: lock bit 0, missing clock bit 1
// - Writing 1 bit 0 clears lock counters
// - Count lock rising and falling edges
// - Bus usable right after hard reset release
// - Bus side clocked by bus clock line; here it runs on mclk, sampling that line through the synchroniser
// - Soft reset spares bus and bank, self-clears
module ccs_cci_slave (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic bus_clock_line,
  input wire logic bus_data_in,
  output logic bus_data_out,
  output logic bus_data_oe,
  input wire logic addr_select_hi,
  input wire logic addr_select_lo,
  input wire logic pll_lock,
  input wire logic ref_clock_missing,
  output logic soft_reset
);

  // Synchroniser stages and the agreed (stable) pin levels
  ccs_pkg::ccs_pins_t pins_raw;
  ccs_pkg::ccs_pins_t sync_a;
  ccs_pkg::ccs_pins_t sync_b;
  ccs_pkg::ccs_pins_t sync_c;
  ccs_pkg::ccs_pins_t pins;
  // Previous stable bus levels for edge detection
  logic scl_prev;
  logic sda_prev;
  // Bus events derived from stable levels
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // Bus engine state
  ccs_pkg::ccs_state_t state;
  logic [3:0] bit_cnt; // Bits shifted in the current byte
  logic [7:0] shreg; // Receive shift register
  logic [7:0] tx_byte; // Transmit shift register
  logic rw_read; // Direction of current transfer
  logic [1:0] phase; // Address hi, address lo, data
  logic [15:0] reg_addr; // Internal register pointer
  logic master_ack; // Master answer after a read byte
  logic [15:0] next_addr; // Pointer plus one
  logic [7:0] rd_now; // Read value at the pointer
  logic [7:0] rd_next; // Read value one past the pointer

  // Register file side
  ccs_pkg::ccs_wreq_t wreq;
  logic [7:0] bank [ccs_pkg::BANK_DEPTH]; // Generic configuration bytes
  logic [7:0] acq_cnt; // Lock rising edge count
  logic [7:0] loss_cnt; // Lock falling edge count
  logic lock_prev; // Previous stable lock level
  logic lock_rise;
  logic lock_fall;
  logic cnt_clear; // Clear request from the host
  logic [7:0] status_byte;

  // Pack the raw pins into one carrier
  assign pins_raw = '{scl: bus_clock_line, sda: bus_data_in, sel_hi: addr_select_hi,
                      sel_lo: addr_select_lo, lock: pll_lock, missing: ref_clock_missing};

  // True when a received address byte is ours
  function automatic logic addr_match(input logic [7:0] b, input logic hi, input logic lo);
    logic local_hit;
    logic global_hit;
    local_hit = (b[7:1] == {ccs_pkg::LOCAL_PREFIX, hi, lo});
    // Global only in write direction; read to it never matches
    global_hit = (b == ccs_pkg::GLOBAL_WR_BYTE);
    addr_match = local_hit | global_hit;
  endfunction

  // Read-back value of any sub-address
  function automatic logic [7:0] reg_read(input logic [15:0] a, input logic [7:0] status,
                                          input logic [7:0] acq, input logic [7:0] loss,
                                          input logic [7:0] bank_word);
    reg_read = ccs_pkg::DATA_ZERO; // Unmapped and write-only read zero
    if (a == ccs_pkg::ADDR_LOCK_STATE) begin
      reg_read = status;
    end else if (a == ccs_pkg::ADDR_ACQ_CNT) begin
      reg_read = acq;
    end else if (a == ccs_pkg::ADDR_LOSS_CNT) begin
      reg_read = loss;
    end else if (a[15:8] == ccs_pkg::BANK_PAGE) begin
      reg_read = bank_word;
    end
  endfunction

  // Three-stage synchroniser; the stable level moves only when stages two and three agree
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sync_a <= ccs_pkg::PINS_IDLE;
      sync_b <= ccs_pkg::PINS_IDLE;
      sync_c <= ccs_pkg::PINS_IDLE;
      pins <= ccs_pkg::PINS_IDLE;
    end else begin
      sync_a <= pins_raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
      // Agreement filter, bitwise hold on disagreement
      pins <= (sync_b & sync_c) | (pins & (sync_b | sync_c));
    end
  end

  // Previous stable bus levels
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= pins.scl;
      sda_prev <= pins.sda;
    end
  end

  // The bus side advances only on edges of the bus clock line and on start/stop data edges, seen through the
  // synchroniser; 50 MHz gives ample margin even at 400 kbit/s
  assign scl_rise = pins.scl & ~scl_prev;
  assign scl_fall = ~pins.scl & scl_prev;
  // Start and stop are data edges while the clock stays high
  assign start_cond = pins.scl & scl_prev & sda_prev & ~pins.sda;
  assign stop_cond = pins.scl & scl_prev & ~sda_prev & pins.sda;

  assign next_addr = reg_addr + ccs_pkg::ADDR_STEP;
  assign status_byte = {6'h00, pins.missing, pins.lock};
  // Read values ready before the falling edge that launches their first bit
  assign rd_now = reg_read(reg_addr, status_byte, acq_cnt, loss_cnt, bank[reg_addr[7:0]]);
  assign rd_next = reg_read(next_addr, status_byte, acq_cnt, loss_cnt, bank[next_addr[7:0]]);

  // Bus engine: framing, acknowledge, pointer handling and read data
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      // Engine is idle and listening as soon as hard reset is released
      state <= ccs_pkg::ST_IDLE;
      bit_cnt <= '0;
      shreg <= '0;
      tx_byte <= '0;
      rw_read <= 1'b0;
      phase <= ccs_pkg::PHASE_ADDR_HI;
      reg_addr <= '0;
      master_ack <= 1'b0;
      bus_data_oe <= 1'b0;
      wreq <= '0;
    end else begin
      // Write strobe lasts one cycle
      wreq.stb <= 1'b0;
      if (start_cond) begin
        // Start or repeated start restarts address reception
        state <= ccs_pkg::ST_ADDR;
        bit_cnt <= '0;
        phase <= ccs_pkg::PHASE_ADDR_HI;
        bus_data_oe <= 1'b0;
      end else if (stop_cond) begin
        // Stop ends any transfer and frees the line
        state <= ccs_pkg::ST_IDLE;
        bus_data_oe <= 1'b0;
      end else begin
        unique case (state)
          ccs_pkg::ST_IDLE: begin
            // Wait for a start
            bus_data_oe <= 1'b0;
          end
          ccs_pkg::ST_ADDR: begin
            // Shift slave address and direction bit on rising edges
            if (scl_rise) begin
              shreg <= {shreg[6:0], pins.sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == ccs_pkg::BITS_PER_BYTE) begin
              bit_cnt <= '0;
              if (addr_match(shreg, pins.sel_hi, pins.sel_lo)) begin
                state <= ccs_pkg::ST_ACK;
                bus_data_oe <= 1'b1;
                rw_read <= shreg[ccs_pkg::RW_BIT];
              end else begin
                // Not ours: stay off the line until the next start
                state <= ccs_pkg::ST_IDLE;
                bus_data_oe <= 1'b0;
              end
            end
          end
          ccs_pkg::ST_ACK: begin
            // Acknowledge bit ends at the next falling edge
            if (scl_fall) begin
              if (rw_read) begin
                // First read byte comes from the pointer set in the write phase
                state <= ccs_pkg::ST_TX;
                tx_byte <= {rd_now[6:0], 1'b0};
                bus_data_oe <= ~rd_now[7];
                bit_cnt <= ccs_pkg::FIRST_BIT_SENT;
              end else begin
                state <= ccs_pkg::ST_RX;
                bus_data_oe <= 1'b0;
                bit_cnt <= '0;
              end
            end
          end
          ccs_pkg::ST_RX: begin
            // Receive address or data bytes from the master
            if (scl_rise) begin
              shreg <= {shreg[6:0], pins.sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == ccs_pkg::BITS_PER_BYTE) begin
              state <= ccs_pkg::ST_ACK;
              bus_data_oe <= 1'b1;
              bit_cnt <= '0;
              unique case (phase)
                ccs_pkg::PHASE_ADDR_HI: begin
                  // High address byte arrives first
                  reg_addr[15:8] <= shreg;
                  phase <= ccs_pkg::PHASE_ADDR_LO;
                end
                ccs_pkg::PHASE_ADDR_LO: begin
                  reg_addr[7:0] <= shreg;
                  phase <= ccs_pkg::PHASE_DATA;
                end
                default: begin
                  // Data byte: post a write and step the pointer
                  wreq <= '{stb: 1'b1, addr: reg_addr, data: shreg};
                  reg_addr <= next_addr;
                end
              endcase
            end
          end
          ccs_pkg::ST_TX: begin
            // Open drain: pull low for zero bits, release for ones
            if (scl_fall) begin
              if (bit_cnt == ccs_pkg::BITS_PER_BYTE) begin
                // Free the line for the master's answer
                state <= ccs_pkg::ST_MACK;
                bus_data_oe <= 1'b0;
              end else begin
                bus_data_oe <= ~tx_byte[7];
                tx_byte <= tx_byte << 1;
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ccs_pkg::ST_MACK: begin
            // Low on the answer bit is an acknowledge
            if (scl_rise) begin
              master_ack <= ~pins.sda;
            end else if (scl_fall) begin
              if (master_ack) begin
                // Continue with the following register
                state <= ccs_pkg::ST_TX;
                reg_addr <= next_addr;
                tx_byte <= {rd_next[6:0], 1'b0};
                bus_data_oe <= ~rd_next[7];
                bit_cnt <= ccs_pkg::FIRST_BIT_SENT;
              end else begin
                // NACK ends the read; wait for stop
                state <= ccs_pkg::ST_IDLE;
                bus_data_oe <= 1'b0;
              end
            end
          end
        endcase
      end
    end
  end

  // Open-drain data line only ever pulls low
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bus_data_out <= 1'b0;
    end else begin
      bus_data_out <= 1'b0;
    end
  end

  // Configuration bank; survives soft reset, cleared only by hard reset.
  // Writes outside the bank page and to read-only registers are dropped silently.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      for (int i = 0; i < ccs_pkg::BANK_DEPTH; i++) begin
        bank[i] <= ccs_pkg::DATA_ZERO;
      end
    end else if (wreq.stb && wreq.addr[15:8] == ccs_pkg::BANK_PAGE) begin
      bank[wreq.addr[7:0]] <= wreq.data;
    end
  end

  // Soft reset request: one-cycle pulse, so the bit clears itself
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= wreq.stb && wreq.addr == ccs_pkg::ADDR_SOFT_RESET
                    && wreq.data[ccs_pkg::SOFT_BIT];
    end
  end

  // Host clear of the lock counters; other bits of that register are ignored
  assign cnt_clear = wreq.stb && wreq.addr == ccs_pkg::ADDR_LOCK_CLR
                     && wreq.data[ccs_pkg::CLR_BIT];

  // Lock level history for edge detection, follows the stable level
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lock_prev <= 1'b0;
    end else begin
      lock_prev <= pins.lock;
    end
  end

  assign lock_rise = pins.lock & ~lock_prev;
  assign lock_fall = ~pins.lock & lock_prev;

  // Lock edge counters; an edge in the clear cycle still counts as one
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      acq_cnt <= ccs_pkg::COUNT_ZERO;
      loss_cnt <= ccs_pkg::COUNT_ZERO;
    end else if (cnt_clear || soft_reset) begin
      // Soft reset clears these too; only bus and bank are spared
      acq_cnt <= lock_rise ? ccs_pkg::COUNT_ONE : ccs_pkg::COUNT_ZERO;
      loss_cnt <= lock_fall ? ccs_pkg::COUNT_ONE : ccs_pkg::COUNT_ZERO;
    end else begin
      // Counters wrap at 255
      if (lock_rise) begin
        acq_cnt <= acq_cnt + ccs_pkg::COUNT_ONE;
      end
      if (lock_fall) begin
        loss_cnt <= loss_cnt + ccs_pkg::COUNT_ONE;
      end
    end
  end

endmodule

// ==== ccs_cci_slave_props.sv ====
// Concurrent checks on the camera control slave ports
`timescale 1ns/10ps
module ccs_cci_slave_props (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic bus_clock_line,
  input wire logic bus_data_in,
  input wire logic bus_data_out,
  input wire logic bus_data_oe,
  input wire logic addr_select_hi,
  input wire logic addr_select_lo,
  input wire logic pll_lock,
  input wire logic ref_clock_missing,
  input wire logic soft_reset
);
  // One domain, so one clocking and one disable
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // Start: data falls while clock high
  sequence start_s;
    bus_clock_line && $fell(bus_data_in);
  endsequence
  // Stop: data rises while clock high
  sequence stop_s;
    bus_clock_line && $rose(bus_data_in);
  endsequence
  drive_zero_a: assert property (bus_data_out == 1'b0)
    else $error("data output value not low");
  oe_move_a: assert property ($changed(bus_data_oe) |-> !bus_clock_line && !$past(bus_clock_line, 3))
    else $error("data enable moved too close to clock high");
  oe_stands_a: assert property ($rose(bus_data_oe) |=> bus_data_oe [*8])
    else $error("acknowledge dropped early");
  start_quiet_a: assert property (start_s |=> !bus_data_oe [*8])
    else $error("data driven right after start");
  stop_quiet_a: assert property (stop_s |=> !bus_data_oe [*8])
    else $error("data driven after stop");
  soft_pulse_a: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset longer than one cycle");
  soft_quiet_a: assert property (soft_reset |-> bus_data_oe ##1 bus_data_oe)
    else $error("acknowledge disturbed by soft reset");
  reset_idle_a: assert property (@(posedge mclk) disable iff (1'b0) !rstn |=> !bus_data_oe && !soft_reset)
    else $error("outputs active in reset");
endmodule

bind ccs_cci_slave ccs_cci_slave_props u_props (.mclk(mclk), .rstn(rstn), .bus_clock_line(bus_clock_line),
  .bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .addr_select_hi(addr_select_hi),
  .addr_select_lo(addr_select_lo), .pll_lock(pll_lock), .ref_clock_missing(ref_clock_missing), .soft_reset(soft_reset));

// ==== ccs_host_model.sv ====
// Two-wire bus master model driving the camera control slave
`timescale 1ns/10ps
module ccs_host_model (
  input wire logic mclk,
  input wire logic dev_oe,
  output logic scl,
  output logic sda
);
  int q_len = 6; // Quarter bit in clocks; 31 gives about 400 kbit/s, 125 gives 100 kbit/s
  logic pull_low; // Master pulls the data line
  // Open-drain wire with pull-up, so a released line reads high
  assign sda = !(pull_low || dev_oe);
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  // Wait n clocks and land just after the edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Start or repeated start
  task automatic start();
    step(q_len);
    pull_low = 1'b0;
    step(q_len);
    scl = 1'b1;
    step(2 * q_len);
    pull_low = 1'b1;
    step(2 * q_len);
    scl = 1'b0;
  endtask
  // Stop, then bus idle
  task automatic stop();
    step(q_len);
    pull_low = 1'b1;
    step(q_len);
    scl = 1'b1;
    step(2 * q_len);
    pull_low = 1'b0;
    step(2 * q_len);
  endtask
  // Eight bits plus the ninth; data moves only while clock low
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      step(q_len);
      pull_low = !d[i];
      step(q_len);
      scl = 1'b1;
      step(q_len);
      q[i] = sda;
      step(q_len);
      scl = 1'b0;
    end
  endtask
endmodule

// ==== ccs_cci_slave_tb_top.sv ====
// Self-checking bench for the camera control slave
`timescale 1ns/10ps
module ccs_cci_slave_tb_top;
  logic mclk;
  logic rstn;
  logic scl;
  logic sda;
  logic oe;
  logic sel_hi;
  logic sel_lo;
  logic pll_lock;
  logic missing;
  logic soft_reset;
  logic [7:0] dev_w; // Local write byte from select pins
  logic [7:0] exp_q[$]; // Notes of expected results
  logic [7:0] got;
  logic [7:0] e;
  logic [8:0] q;
  logic [7:0] dv[3];
  int err_count;
  int tests_run;
  int seed;
  int soft_seen;
  int lock_pulses;
  event got_ev;
  assign dev_w = {ccs_pkg::LOCAL_PREFIX, sel_hi, sel_lo, 1'b0};
  ccs_cci_slave uut (.mclk(mclk), .rstn(rstn), .bus_clock_line(scl), .bus_data_in(sda), .bus_data_out(),
    .bus_data_oe(oe), .addr_select_hi(sel_hi), .addr_select_lo(sel_lo), .pll_lock(pll_lock),
    .ref_clock_missing(missing), .soft_reset(soft_reset));
  ccs_host_model host (.mclk(mclk), .dev_oe(oe), .scl(scl), .sda(sda));
  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = !mclk;
  end
  // Count soft reset pulses
  always @(negedge mclk) begin
    if (soft_reset === 1'b1) soft_seen++;
  end
  // Compare each result with the oldest note
  initial begin
    forever begin
      @(got_ev);
      e = exp_q.pop_front();
      tests_run++;
      if (got !== e) begin
        err_count++;
        $display("unexpected at %0t: got %h expected %h", $time, got, e);
      end
    end
  end
  task automatic publish(input logic [7:0] g);
    got = g;
    -> got_ev;
  endtask
  // One byte out, acknowledge level noted first
  task automatic wb(input logic [7:0] b, input logic a);
    exp_q.push_back({7'h00, a});
    host.xfer({b, 1'b1}, q);
    publish({7'h00, q[0]});
  endtask
  // Device byte, then register address high byte first
  task automatic head(input logic [7:0] dev, input logic [15:0] ra);
    host.start();
    wb(dev, 1'b0);
    wb(ra[15:8], 1'b0);
    wb(ra[7:0], 1'b0);
  endtask
  task automatic wr(input logic [7:0] dev, input logic [15:0] ra, input logic [7:0] d[$]);
    head(dev, ra);
    foreach (d[i]) wb(d[i], 1'b0);
    host.stop();
  endtask
  // Burst read; the master acks all but the last byte
  task automatic rd(input logic [15:0] ra, input logic [7:0] x[$]);
    head(dev_w, ra);
    host.start();
    wb(dev_w | 8'h01, 1'b0);
    foreach (x[i]) begin
      exp_q.push_back(x[i]);
      host.xfer({8'hFF, i == x.size() - 1}, q);
      publish(q[8:1]);
    end
    host.stop();
  endtask
  // A lone address byte that should be refused
  task automatic probe(input logic [7:0] b);
    host.start();
    wb(b, 1'b1);
    host.stop();
  endtask
  task automatic stop_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    seed = 51086;
    err_count = 0;
    tests_run = 0;
    soft_seen = 0;
    rstn = 1'b0;
    {sel_hi, sel_lo} = 2'($random(seed));
    pll_lock = 1'b0;
    missing = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    rstn = 1'b1;
    host.step(4);
    rd(ccs_pkg::ADDR_LOCK_STATE, '{8'h02});
    pll_lock = 1'b1;
    missing = 1'b0;
    host.step(20);
    rd(ccs_pkg::ADDR_LOCK_STATE, '{8'h01});
    // Random number of lock drop and regain pairs
    lock_pulses = ($random(seed) & 3) + 1;
    for (int p = 0; p < 2 * lock_pulses; p++) begin
      pll_lock = !pll_lock;
      host.step(20);
    end
    rd(ccs_pkg::ADDR_ACQ_CNT, '{8'(lock_pulses + 1), 8'(lock_pulses)});
    wr(dev_w, ccs_pkg::ADDR_LOCK_CLR, '{8'h01});
    rd(ccs_pkg::ADDR_LOCK_CLR, '{8'h00, 8'h00, 8'h00, 8'h00});
    wr(dev_w, ccs_pkg::ADDR_LOCK_STATE, '{8'hFF});
    missing = 1'($random(seed));
    rd(ccs_pkg::ADDR_LOCK_STATE, '{{6'h00, missing, 1'b1}});
    wr(dev_w, 16'h401E, '{8'h02});
    wr(dev_w, 16'h4038, '{8'h3B});
    host.q_len = 31;
    rd(16'h401E, '{8'h02});
    host.q_len = 125;
    rd(16'h4038, '{8'h3B});
    host.q_len = 6;
    foreach (dv[i]) dv[i] = 8'($random(seed));
    wr(dev_w, 16'h40FE, '{dv[0], dv[1], dv[2]});
    rd(16'h40FE, '{dv[0], dv[1], 8'h00});
    wr(ccs_pkg::GLOBAL_WR_BYTE, 16'h4010, '{dv[2]});
    rd(16'h4010, '{dv[2]});
    probe(ccs_pkg::GLOBAL_WR_BYTE | 8'h01);
    for (int k = 0; k < 4; k++) begin
      {sel_hi, sel_lo} = 2'(k);
      host.step(10);
      probe(dev_w ^ 8'h06);
      dv[0] = 8'($random(seed));
      wr(dev_w, 16'h4020 + 16'(k), '{dv[0]});
      rd(16'h4020 + 16'(k), '{dv[0]});
    end
    pll_lock = 1'b0;
    host.step(20);
    wr(dev_w, ccs_pkg::ADDR_SOFT_RESET, '{8'h01});
    exp_q.push_back(8'h01);
    publish(8'(soft_seen));
    rd(ccs_pkg::ADDR_ACQ_CNT, '{8'h00, 8'h00});
    rd(16'h401E, '{8'h02});
    rstn = 1'b0;
    host.step(4);
    stop_test();
  end
endmodule
